// ---- rtl/cfg_router_defines.svh ----
// constants for the configuration access router
`ifndef CFG_ROUTER_DEFINES_SVH
`define CFG_ROUTER_DEFINES_SVH
`define ADDR_PORT_IO 16'h0cf8
`define DATA_PORT_IO 16'h0cfc
`define ADDR_PORT_RESET 32'h0000_0000
`define ADDR_PORT_WMASK 32'h80ff_fffc
`define ENABLE_BIT 31
`define BUS_HI 23
`define BUS_LO 16
`define DEV_HI 15
`define DEV_LO 11
`define FUNC_HI 10
`define FUNC_LO 8
`define REG_HI 7
`define REG_LO 2
`define BE_DWORD 4'hf
`define BUS_ZERO 8'h00
`define FUNC_ZERO 3'h0
`define DEV_HOST 5'h00
`define DEV_GFX 5'h01
`define BUSNUM_REG_IDX 6'h06
`define PRIMARY_BUS 8'h00
`define BYTE_RESET 8'h00
`define CYC_TYPE0 2'b00
`define CYC_TYPE1 2'b01
`define IGNORED_DATA 32'hffff_ffff
`define ZERO_WORD 32'h0000_0000
`define IO_ADDR_PAD 16'h0000
`define CFG_ADDR_PAD 8'h00
`endif

// ---- rtl/cfg_router_pkg.sv ----
// types shared by the configuration access router
package cfg_router_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOCAL = 2'b01,
      ST_FWD = 2'b10,
      ST_RESP = 2'b11
   } router_state_t;
   typedef enum logic [1:0] {
      KIND_IO = 2'b00,
      KIND_CFG0 = 2'b01,
      KIND_CFG1 = 2'b10
   } fwd_kind_t;
endpackage : cfg_router_pkg

// ---- rtl/cfg_fwd_if.sv ----
// request and answer bundle between the router and one downstream port
`timescale 1ns/1ns
interface cfg_fwd_if;
   logic start;
   cfg_router_pkg::fwd_kind_t kind;
   logic write;
   logic [31:0] addr;
   logic [3:0] be;
   logic [31:0] wdata;
   logic done;
   logic [31:0] rdata;
   modport ctl (output start, output kind, output write, output addr, output be, output wdata,
                input done, input rdata);
   modport port (input start, input kind, input write, input addr, input be, input wdata,
                 output done, output rdata);
endinterface : cfg_fwd_if

// ---- rtl/fwd_port.sv ----
// one downstream port: holds a forwarded cycle until the far side completes it
`timescale 1ns/1ns
`include "cfg_router_defines.svh"
module fwd_port (
   input wire logic clk,
   input wire logic rst_n,
   cfg_fwd_if.port req,
   output logic dn_valid,
   output cfg_router_pkg::fwd_kind_t dn_kind,
   output logic dn_write,
   output logic [31:0] dn_addr,
   output logic [3:0] dn_be,
   output logic [31:0] dn_wdata,
   input wire logic dn_done,
   input wire logic [31:0] dn_rdata
);
   logic busy_r, busy_nxt;
   logic done_r, done_nxt;
   cfg_router_pkg::fwd_kind_t kind_r, kind_nxt;
   logic write_r, write_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [3:0] be_r, be_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // capture on start, release on the far side's done
   always_comb begin
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      kind_nxt = kind_r;
      write_nxt = write_r;
      addr_nxt = addr_r;
      be_nxt = be_r;
      wdata_nxt = wdata_r;
      rdata_nxt = rdata_r;
      if (busy_r) begin
         if (dn_done) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
            rdata_nxt = dn_rdata;
         end
      end else if (req.start) begin
         busy_nxt = 1'b1;
         kind_nxt = req.kind;
         write_nxt = req.write;
         addr_nxt = req.addr;
         be_nxt = req.be;
         wdata_nxt = req.wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         kind_r <= cfg_router_pkg::KIND_IO;
         write_r <= 1'b0;
         addr_r <= `ZERO_WORD;
         be_r <= 4'h0;
         wdata_r <= `ZERO_WORD;
         rdata_r <= `ZERO_WORD;
      end else begin
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         kind_r <= kind_nxt;
         write_r <= write_nxt;
         addr_r <= addr_nxt;
         be_r <= be_nxt;
         wdata_r <= wdata_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // a done seen outside a cycle is ignored, so a stray strobe cannot fake an answer
   assign dn_valid = busy_r;
   assign dn_kind = kind_r;
   assign dn_write = write_r;
   assign dn_addr = addr_r;
   assign dn_be = be_r;
   assign dn_wdata = wdata_r;
   assign req.done = done_r;
   assign req.rdata = rdata_r;
endmodule : fwd_port

// ---- rtl/bus_number_regs.sv ----
// bus number dword of the graphics bridge: primary, secondary, highest bus id, latency
`timescale 1ns/1ns
`include "cfg_router_defines.svh"
module bus_number_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr,
   input wire logic [3:0] be,
   input wire logic [31:0] wdata,
   output logic [31:0] rdata,
   output logic [7:0] secondary_bus,
   output logic [7:0] highest_bus_id
);
   logic [7:0] sec_r, sec_nxt;
   logic [7:0] sub_r, sub_nxt;
   logic [7:0] lat_r, lat_nxt;

   // byte lanes land little-endian; lane 0 is the fixed primary number
   always_comb begin
      sec_nxt = sec_r;
      sub_nxt = sub_r;
      lat_nxt = lat_r;
      if (wr && be[1]) sec_nxt = wdata[15:8];
      if (wr && be[2]) sub_nxt = wdata[23:16];
      if (wr && be[3]) lat_nxt = wdata[31:24];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_r <= `BYTE_RESET;
         sub_r <= `BYTE_RESET;
         lat_r <= `BYTE_RESET;
      end else begin
         sec_r <= sec_nxt;
         sub_r <= sub_nxt;
         lat_r <= lat_nxt;
      end
   end

   // primary bus number reads as zero and ignores writes
   assign rdata = {lat_r, sub_r, sec_r, `PRIMARY_BUS};
   assign secondary_bus = sec_r;
   assign highest_bus_id = sub_r;
endmodule : bus_number_regs

// ---- rtl/pci_config_access_router.sv ----
// configuration access router: address port, data window and cycle routing
`timescale 1ns/1ns
`include "cfg_router_defines.svh"
module pci_config_access_router (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic io_req,
   input wire logic io_write,
   input wire logic [15:0] io_addr,
   input wire logic [3:0] io_be,
   input wire logic [31:0] io_wdata,
   output logic io_ack,
   output logic [31:0] io_rdata,
   input wire logic [1:0] dev_enable,
   output logic loc_req,
   output logic loc_write,
   output logic [4:0] loc_dev,
   output logic [5:0] loc_reg,
   output logic [3:0] loc_be,
   output logic [31:0] loc_wdata,
   input wire logic loc_ack,
   input wire logic [31:0] loc_rdata,
   output logic south_hub_link_valid,
   output cfg_router_pkg::fwd_kind_t south_hub_link_kind,
   output logic south_hub_link_write,
   output logic [31:0] south_hub_link_addr,
   output logic [3:0] south_hub_link_be,
   output logic [31:0] south_hub_link_wdata,
   input wire logic south_hub_link_done,
   input wire logic [31:0] south_hub_link_rdata,
   output logic gfx_valid,
   output cfg_router_pkg::fwd_kind_t gfx_kind,
   output logic gfx_write,
   output logic [31:0] gfx_addr,
   output logic [3:0] gfx_be,
   output logic [31:0] gfx_wdata,
   input wire logic gfx_done,
   input wire logic [31:0] gfx_rdata
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // dword match of an io address against a port base
   function automatic logic dword_hit(input logic [15:0] a, input logic [15:0] base);
      dword_hit = (a[15:2] == base[15:2]);
   endfunction : dword_hit

   // config address passed downstream with the cycle type in the low bits
   function automatic logic [31:0] cfg_word(input logic [31:0] ap, input logic [1:0] typ);
      cfg_word = {`CFG_ADDR_PAD, ap[`BUS_HI:`REG_LO], typ};
   endfunction : cfg_word

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cfg_router_pkg::router_state_t state_r, state_nxt;
   logic [31:0] addr_port_r, addr_port_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic gfx_sel_r, gfx_sel_nxt;
   logic write_r, write_nxt;
   logic [3:0] be_r, be_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [4:0] dev_r, dev_nxt;
   logic [5:0] reg_r, reg_nxt;

   cfg_fwd_if hub_if ();
   cfg_fwd_if gfx_if ();

   logic bn_wr;
   logic [31:0] bn_rdata;
   logic [7:0] sec_bus;
   logic [7:0] hi_bus;

   // decoded fields of the address port
   logic cfg_en;
   logic [7:0] bus_num;
   logic [4:0] dev_num;
   logic [2:0] func_num;
   logic [5:0] reg_num;
   assign cfg_en = addr_port_r[`ENABLE_BIT];
   assign bus_num = addr_port_r[`BUS_HI:`BUS_LO];
   assign dev_num = addr_port_r[`DEV_HI:`DEV_LO];
   assign func_num = addr_port_r[`FUNC_HI:`FUNC_LO];
   assign reg_num = addr_port_r[`REG_HI:`REG_LO];

   bus_number_regs u_bus_regs (
      .clk(clk),
      .rst_n(rst_n),
      .wr(bn_wr),
      .be(io_be),
      .wdata(io_wdata),
      .rdata(bn_rdata),
      .secondary_bus(sec_bus),
      .highest_bus_id(hi_bus)
   );

   fwd_port u_hub_port (
      .clk(clk),
      .rst_n(rst_n),
      .req(hub_if),
      .dn_valid(south_hub_link_valid),
      .dn_kind(south_hub_link_kind),
      .dn_write(south_hub_link_write),
      .dn_addr(south_hub_link_addr),
      .dn_be(south_hub_link_be),
      .dn_wdata(south_hub_link_wdata),
      .dn_done(south_hub_link_done),
      .dn_rdata(south_hub_link_rdata)
   );

   fwd_port u_gfx_port (
      .clk(clk),
      .rst_n(rst_n),
      .req(gfx_if),
      .dn_valid(gfx_valid),
      .dn_kind(gfx_kind),
      .dn_write(gfx_write),
      .dn_addr(gfx_addr),
      .dn_be(gfx_be),
      .dn_wdata(gfx_wdata),
      .dn_done(gfx_done),
      .dn_rdata(gfx_rdata)
   );

   // ----------------------------------------------------------------
   // routing decision and sequencing
   // ----------------------------------------------------------------
   // one request at a time; io_req outside idle is not looked at
   always_comb begin
      state_nxt = state_r;
      addr_port_nxt = addr_port_r;
      rdata_nxt = rdata_r;
      gfx_sel_nxt = gfx_sel_r;
      write_nxt = write_r;
      be_nxt = be_r;
      wdata_nxt = wdata_r;
      dev_nxt = dev_r;
      reg_nxt = reg_r;
      bn_wr = 1'b0;
      hub_if.start = 1'b0;
      hub_if.kind = cfg_router_pkg::KIND_IO;
      hub_if.write = io_write;
      hub_if.addr = {`IO_ADDR_PAD, io_addr};
      hub_if.be = io_be;
      hub_if.wdata = io_wdata;
      gfx_if.start = 1'b0;
      gfx_if.kind = cfg_router_pkg::KIND_CFG0;
      gfx_if.write = io_write;
      gfx_if.addr = cfg_word(addr_port_r, `CYC_TYPE0);
      gfx_if.be = io_be;
      gfx_if.wdata = io_wdata;
      unique case (state_r)
         cfg_router_pkg::ST_IDLE: begin
            if (io_req) begin
               write_nxt = io_write;
               be_nxt = io_be;
               wdata_nxt = io_wdata;
               dev_nxt = dev_num;
               reg_nxt = reg_num;
               if (dword_hit(io_addr, `ADDR_PORT_IO) && io_be == `BE_DWORD) begin
                  // whole dword only; reserved bits are forced so no merge is needed
                  if (io_write) addr_port_nxt = io_wdata & `ADDR_PORT_WMASK;
                  rdata_nxt = addr_port_r;
                  state_nxt = cfg_router_pkg::ST_RESP;
               end else if (dword_hit(io_addr, `DATA_PORT_IO) && cfg_en) begin
                  if (bus_num == `BUS_ZERO) begin
                     if (dev_num == `DEV_HOST || dev_num == `DEV_GFX) begin
                        if (!dev_enable[dev_num[0]]) begin
                           hub_if.start = 1'b1;
                           hub_if.kind = cfg_router_pkg::KIND_CFG0;
                           hub_if.addr = cfg_word(addr_port_r, `CYC_TYPE0);
                           gfx_sel_nxt = 1'b0;
                           state_nxt = cfg_router_pkg::ST_FWD;
                        end else if (func_num != `FUNC_ZERO) begin
                           rdata_nxt = `IGNORED_DATA;
                           state_nxt = cfg_router_pkg::ST_RESP;
                        end else if (dev_num == `DEV_GFX && reg_num == `BUSNUM_REG_IDX) begin
                           bn_wr = io_write;
                           rdata_nxt = bn_rdata;
                           state_nxt = cfg_router_pkg::ST_RESP;
                        end else begin
                           state_nxt = cfg_router_pkg::ST_LOCAL;
                        end
                     end else begin
                        hub_if.start = 1'b1;
                        hub_if.kind = cfg_router_pkg::KIND_CFG0;
                        hub_if.addr = cfg_word(addr_port_r, `CYC_TYPE0);
                        gfx_sel_nxt = 1'b0;
                        state_nxt = cfg_router_pkg::ST_FWD;
                     end
                  end else if (bus_num == sec_bus) begin
                     gfx_if.start = 1'b1;
                     gfx_sel_nxt = 1'b1;
                     state_nxt = cfg_router_pkg::ST_FWD;
                  end else if (bus_num > sec_bus && bus_num <= hi_bus) begin
                     gfx_if.start = 1'b1;
                     gfx_if.kind = cfg_router_pkg::KIND_CFG1;
                     gfx_if.addr = cfg_word(addr_port_r, `CYC_TYPE1);
                     gfx_sel_nxt = 1'b1;
                     state_nxt = cfg_router_pkg::ST_FWD;
                  end else begin
                     hub_if.start = 1'b1;
                     hub_if.kind = cfg_router_pkg::KIND_CFG1;
                     hub_if.addr = cfg_word(addr_port_r, `CYC_TYPE1);
                     gfx_sel_nxt = 1'b0;
                     state_nxt = cfg_router_pkg::ST_FWD;
                  end
               end else begin
                  // partial address-port access, disabled window, or any other io
                  hub_if.start = 1'b1;
                  gfx_sel_nxt = 1'b0;
                  state_nxt = cfg_router_pkg::ST_FWD;
               end
            end
         end
         cfg_router_pkg::ST_LOCAL: begin
            // reserved locations answer whatever the register file returns
            if (loc_ack) begin
               rdata_nxt = loc_rdata;
               state_nxt = cfg_router_pkg::ST_RESP;
            end
         end
         cfg_router_pkg::ST_FWD: begin
            if (gfx_sel_r ? gfx_if.done : hub_if.done) begin
               rdata_nxt = gfx_sel_r ? gfx_if.rdata : hub_if.rdata;
               state_nxt = cfg_router_pkg::ST_RESP;
            end
         end
         cfg_router_pkg::ST_RESP: begin
            state_nxt = cfg_router_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= cfg_router_pkg::ST_IDLE;
         addr_port_r <= `ADDR_PORT_RESET;
         rdata_r <= `ZERO_WORD;
         gfx_sel_r <= 1'b0;
         write_r <= 1'b0;
         be_r <= 4'h0;
         wdata_r <= `ZERO_WORD;
         dev_r <= `DEV_HOST;
         reg_r <= 6'h00;
      end else begin
         state_r <= state_nxt;
         addr_port_r <= addr_port_nxt;
         rdata_r <= rdata_nxt;
         gfx_sel_r <= gfx_sel_nxt;
         write_r <= write_nxt;
         be_r <= be_nxt;
         wdata_r <= wdata_nxt;
         dev_r <= dev_nxt;
         reg_r <= reg_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // lanes keep their byte positions, so byte 0 is the least significant
   assign io_ack = (state_r == cfg_router_pkg::ST_RESP);
   assign io_rdata = rdata_r;
   assign loc_req = (state_r == cfg_router_pkg::ST_LOCAL);
   assign loc_write = write_r;
   assign loc_dev = dev_r;
   assign loc_reg = reg_r;
   assign loc_be = be_r;
   assign loc_wdata = wdata_r;
endmodule : pci_config_access_router

// ---- dv/cfg_router_props.sv ----
// port-level checker of the configuration access router
`timescale 1ns/1ns
module cfg_router_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic io_ack,
   input wire logic loc_req,
   input wire logic loc_ack,
   input wire logic [4:0] loc_dev,
   input wire logic south_hub_link_valid,
   input wire cfg_router_pkg::fwd_kind_t south_hub_link_kind,
   input wire logic [31:0] south_hub_link_addr,
   input wire logic south_hub_link_done,
   input wire logic gfx_valid,
   input wire cfg_router_pkg::fwd_kind_t gfx_kind,
   input wire logic [31:0] gfx_addr,
   input wire logic gfx_done
);
   // ------------------------------------------------------------
   // handshake and routing relations
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // answer is a single-cycle pulse, so the host never double counts
   ack_pulse_a: assert property (io_ack |=> !io_ack) else $error("io_ack held over two cycles");
   hub_hold_a: assert property (south_hub_link_valid && !south_hub_link_done |=>
      south_hub_link_valid && $stable(south_hub_link_addr)) else $error("hub request changed before done");
   gfx_hold_a: assert property (gfx_valid && !gfx_done |=>
      gfx_valid && $stable(gfx_addr)) else $error("graphics request changed before done");
   loc_hold_a: assert property (loc_req && !loc_ack |=> loc_req && $stable(loc_dev)) else $error("local request moved");
   loc_dev_a: assert property (loc_req |-> loc_dev <= 5'h01) else $error("local access to a foreign device");
   local_only_a: assert property (loc_req |-> !south_hub_link_valid && !gfx_valid) else $error("local cycle forwarded");
   hub_answer_a: assert property (south_hub_link_valid && south_hub_link_done |-> ##2 io_ack)
      else $error("hub completion not answered in two cycles");
   loc_answer_a: assert property (loc_req && loc_ack |=> io_ack && !loc_req) else $error("local completion not answered");
   gfx_type_a: assert property (gfx_valid |-> gfx_kind != cfg_router_pkg::KIND_IO &&
      gfx_addr[1:0] == ((gfx_kind == cfg_router_pkg::KIND_CFG1) ? 2'b01 : 2'b00)) else $error("graphics cycle type wrong");
   hub_type_a: assert property (south_hub_link_valid && south_hub_link_kind == cfg_router_pkg::KIND_CFG1 |->
      south_hub_link_addr[1:0] == 2'b01 && south_hub_link_addr[31:24] == 8'h00) else $error("hub type 1 address wrong");
endmodule : cfg_router_props

bind pci_config_access_router cfg_router_props chk (.clk(clk), .rst_n(rst_n), .io_ack(io_ack), .loc_req(loc_req),
   .loc_ack(loc_ack), .loc_dev(loc_dev), .south_hub_link_valid(south_hub_link_valid),
   .south_hub_link_kind(south_hub_link_kind), .south_hub_link_addr(south_hub_link_addr),
   .south_hub_link_done(south_hub_link_done), .gfx_valid(gfx_valid), .gfx_kind(gfx_kind), .gfx_addr(gfx_addr),
   .gfx_done(gfx_done));

// ---- dv/far_responder.sv ----
// far side model: completes a held request promptly or after a stall
`timescale 1ns/1ns
module far_responder #(
   parameter logic [3:0] answer_tag = 4'h0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic valid,
   input wire cfg_router_pkg::fwd_kind_t kind,
   input wire logic [31:0] addr,
   output logic done,
   output logic [31:0] rdata
);
   logic [3:0] wait_r;
   // ------------------------------------------------------------
   // answer sequencing
   // ------------------------------------------------------------
   // rdata toggles outside the answer cycle so a stale sample never matches
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 4'h0;
         done <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         done <= 1'b0;
         rdata <= ~rdata;
         if (valid && !done) begin
            if (wait_r == (slow ? 4'h5 : 4'h0)) begin
               done <= 1'b1;
               rdata <= addr ^ {answer_tag, 2'b00, kind, 24'h00_0000}; // answer names port and kind
               wait_r <= 4'h0;
            end else begin
               wait_r <= wait_r + 4'h1;
            end
         end
      end
   end
endmodule : far_responder

// ---- dv/testbench.sv ----
// self-checking bench of the configuration access router
`timescale 1ns/1ns
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic io_req = 1'b0;
   logic io_write = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [3:0] io_be = 4'h0;
   logic [31:0] io_wdata = 32'h0000_0000;
   logic [1:0] dev_enable = 2'b11;
   logic slow = 1'b0;
   logic io_ack, loc_req, loc_write, loc_ack, hub_valid, hub_write, hub_done, gfx_valid, gfx_write, gfx_done;
   logic [4:0] loc_dev;
   logic [5:0] loc_reg;
   logic [3:0] loc_be, hub_be, gfx_be;
   logic [31:0] io_rdata, loc_wdata, loc_rdata, hub_addr, hub_wdata, hub_rdata, gfx_addr, gfx_wdata, gfx_rdata;
   cfg_router_pkg::fwd_kind_t hub_kind, gfx_kind;
   int n_mismatch = 0;
   int total_checks = 0;
   logic [31:0] rnd = 32'h0000_c6fa;
   logic [32:0] notes[$];
   logic [32:0] nt;
   logic [7:0] bt [6] = '{8'h10, 8'h11, 8'h30, 8'h31, 8'h05, 8'hff};
   logic [4:0] d5;
   logic [2:0] f3;
   logic [5:0] r6;
   logic [31:0] ea;

   always #25 clk = ~clk;

   pci_config_access_router DUT (.clk(clk), .rst_n(rst_n), .io_req(io_req), .io_write(io_write), .io_addr(io_addr),
      .io_be(io_be), .io_wdata(io_wdata), .io_ack(io_ack), .io_rdata(io_rdata), .dev_enable(dev_enable),
      .loc_req(loc_req), .loc_write(loc_write), .loc_dev(loc_dev), .loc_reg(loc_reg), .loc_be(loc_be),
      .loc_wdata(loc_wdata), .loc_ack(loc_ack), .loc_rdata(loc_rdata), .south_hub_link_valid(hub_valid),
      .south_hub_link_kind(hub_kind), .south_hub_link_write(hub_write), .south_hub_link_addr(hub_addr),
      .south_hub_link_be(hub_be), .south_hub_link_wdata(hub_wdata), .south_hub_link_done(hub_done),
      .south_hub_link_rdata(hub_rdata), .gfx_valid(gfx_valid), .gfx_kind(gfx_kind), .gfx_write(gfx_write),
      .gfx_addr(gfx_addr), .gfx_be(gfx_be), .gfx_wdata(gfx_wdata), .gfx_done(gfx_done), .gfx_rdata(gfx_rdata));
   // local register file answers with device, register and lanes it saw
   far_responder #(.answer_tag(4'hc)) loc_side (.clk(clk), .rst_n(rst_n), .slow(slow), .valid(loc_req),
      .kind(cfg_router_pkg::KIND_IO), .addr({11'h000, loc_dev, 2'b00, loc_reg, 4'h0, loc_be}), .done(loc_ack),
      .rdata(loc_rdata));
   far_responder #(.answer_tag(4'ha)) hub_side (.clk(clk), .rst_n(rst_n), .slow(slow), .valid(hub_valid),
      .kind(hub_kind), .addr(hub_addr), .done(hub_done), .rdata(hub_rdata));
   far_responder #(.answer_tag(4'h5)) gfx_side (.clk(clk), .rst_n(rst_n), .slow(slow), .valid(gfx_valid),
      .kind(gfx_kind), .addr(gfx_addr), .done(gfx_done), .rdata(gfx_rdata));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   // value a far port returns for a request it got
   function automatic logic [31:0] fwd(input logic [3:0] tag, input logic [1:0] kind, input logic [31:0] a);
      fwd = a ^ {tag, 2'b00, kind, 24'h00_0000};
   endfunction : fwd
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic conclude;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // one host access; request is a one-cycle pulse, then wait for the answer
   task automatic io_op(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] d,
                        input logic [32:0] note);
      int n;
      notes.push_back(note);
      @(posedge clk);
      #1;
      rnd = lfsr(rnd);
      io_req = 1'b1;
      io_write = w;
      io_addr = a;
      io_be = be;
      io_wdata = w ? d : rnd;
      @(posedge clk);
      #1;
      io_req = 1'b0;
      n = 0;
      while (io_ack !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 40) begin
         n_mismatch++;
         conclude();
      end
   endtask : io_op
   task automatic rd(input logic [15:0] a, input logic [3:0] be, input logic [31:0] exp);
      io_op(1'b0, a, be, 32'h0000_0000, {1'b1, exp});
   endtask : rd
   task automatic wr(input logic [15:0] a, input logic [3:0] be, input logic [31:0] d);
      io_op(1'b1, a, be, d, {1'b0, 32'h0000_0000});
   endtask : wr
   // full dword load of the address port, enable set
   task automatic sel(input logic [7:0] b, input logic [4:0] d, input logic [2:0] f, input logic [5:0] r);
      wr(16'h0cf8, 4'hf, {1'b1, 7'h00, b, d, f, r, 2'b00});
   endtask : sel

   // ------------------------------------------------------------
   // answer monitor: oldest note against each answer
   // ------------------------------------------------------------
   always @(negedge clk) begin
      if (io_ack === 1'b1) begin
         if (notes.size() == 0) begin
            check("unexpected io_ack", 32'h0000_0001, 32'h0000_0000);
         end else begin
            nt = notes.pop_front();
            if (nt[32]) check("io_rdata", io_rdata, nt[31:0]);
         end
      end
      // forwarded and local cycles carry the host's lanes and data unchanged
      if (hub_valid === 1'b1) check("hub_wdata", hub_wdata, io_wdata);
      if (hub_valid === 1'b1) check("hub_be", {hub_write, hub_be}, {io_write, io_be});
      if (gfx_valid === 1'b1) check("gfx_wdata", gfx_wdata, io_wdata);
      if (gfx_valid === 1'b1) check("gfx_be", {gfx_write, gfx_be}, {io_write, io_be});
      if (loc_req === 1'b1) check("loc_wdata", loc_wdata, io_wdata);
      if (loc_req === 1'b1) check("loc_write", loc_write, io_write);
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      check("idle outputs", {28'h0, io_ack, loc_req, hub_valid, gfx_valid}, 32'h0000_0000);
      rd(16'h0cf8, 4'hf, 32'h0000_0000);
      wr(16'h0cf8, 4'hf, 32'hffff_ffff);
      rd(16'h0cf8, 4'hf, 32'h80ff_fffc);
      wr(16'h0cf8, 4'h1, 32'h0000_0000);
      rd(16'h0cf8, 4'h3, fwd(4'ha, 2'b00, 32'h0000_0cf8));
      rd(16'h0cf8, 4'hf, 32'h80ff_fffc);
      wr(16'h0cf8, 4'hf, 32'h0000_0000);
      rd(16'h0cfc, 4'hf, fwd(4'ha, 2'b00, 32'h0000_0cfc));
      rd(16'h0080, 4'hf, fwd(4'ha, 2'b00, 32'h0000_0080));
      // internal devices: enabled, foreign function, disabled
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         slow = rnd[3];
         r6 = (rnd[5:0] == 6'h06) ? 6'h07 : rnd[5:0];
         d5 = {4'h0, i[0]};
         sel(8'h00, d5, 3'h0, r6);
         rd(16'h0cfc, 4'hf, 32'hc000_0000 | {11'h000, d5, 2'b00, r6, 8'h0f});
         wr(16'h0cfc, 4'hf, rnd);
         sel(8'h00, d5, {1'b0, i[1:0]} + 3'h1, r6);
         rd(16'h0cfc, 4'hf, 32'hffff_ffff);
         dev_enable = i[0] ? 2'b01 : 2'b10;
         sel(8'h00, d5, 3'h0, r6);
         rd(16'h0cfc, 4'hf, fwd(4'ha, 2'b01, {8'h00, 8'h00, d5, 3'h0, r6, 2'b00}));
         dev_enable = 2'b11;
      end
      sel(8'h00, 5'h02, 3'h0, 6'h04);
      rd(16'h0cfc, 4'hf, fwd(4'ha, 2'b01, 32'h0000_1010));
      // bus number dword: primary fixed, byte lane update
      sel(8'h00, 5'h01, 3'h0, 6'h06);
      wr(16'h0cfc, 4'hf, 32'h4420_10ff);
      rd(16'h0cfc, 4'hf, 32'h4420_1000);
      wr(16'h0cfe, 4'h4, 32'h0030_0000);
      rd(16'h0cfc, 4'hf, 32'h4430_1000);
      // routing around secondary 10h and highest 30h
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         slow = rnd[9];
         d5 = rnd[4:0];
         f3 = rnd[7:5];
         r6 = rnd[13:8];
         ea = {8'h00, bt[i], d5, f3, r6, (i == 0) ? 2'b00 : 2'b01};
         sel(bt[i], d5, f3, r6);
         rd(16'h0cfc, 4'hf, fwd((i < 3) ? 4'h5 : 4'ha, (i == 0) ? 2'b01 : 2'b10, ea));
         wr(16'h0cfc, rnd[19:16], rnd);
      end
      // second reset clears port and bus window; let the last answer be taken first
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      rd(16'h0cf8, 4'hf, 32'h0000_0000);
      sel(8'h20, 5'h03, 3'h0, 6'h02);
      rd(16'h0cfc, 4'hf, fwd(4'ha, 2'b10, 32'h0020_1809));
      @(posedge clk);
      check("pending notes", notes.size(), 0);
      conclude();
   end

   // watchdog far beyond the few hundred cycles the scenarios take
   initial begin
      #(50 * 20000);
      n_mismatch++;
      conclude();
   end
endmodule : testbench
